//--- core/port5_6_7_io_ports.sv
// Input-only port, chip-select port and pulse-width/capture port with their register file.
//
module port5_6_7_io_ports (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire port_pkg::bus_req_t    bus,
   output logic [15:0]                rdata,
   input  wire logic [15:0]           input_pins,
   output logic [5:0]                 timer_alt_in,
   input  wire logic [1:0]            cs_count_strap,
   input  wire logic [4:0]            chip_select_n,
   input  wire logic                  arbitration_enable,
   input  wire logic                  hold_mode,
   input  wire logic                  bus_hold_ack_n,
   input  wire logic                  bus_request_n,
   output logic                       hold_request_n,
   input  wire logic [7:0]            cs_pin_in,
   output port_pkg::pin_drive_t       cs_pins,
   output logic [7:0]                 cs_pullup,
   input  wire logic [3:0]            pwm_channel_out,
   input  wire logic [3:0]            pwm_output_enable,
   input  wire logic [3:0]            capcmp_out,
   output logic [3:0]                 capcmp_in,
   input  wire logic [7:0]            third_pin_in,
   output port_pkg::pin_drive_t       third_pins
);

   typedef struct packed {
      logic [7:0]  cs_data;
      logic [7:0]  cs_dir;
      logic [7:0]  cs_od;
      logic [7:0]  third_data;
      logic [7:0]  third_dir;
      logic [7:0]  third_od;
      logic [15:0] rdata;
      logic [5:0]  timer_alt;
      logic        hold_req_n;
      logic [3:0]  capcmp;
      logic [7:0]  pull_on;
   } state_t;

   state_t                 state;
   state_t                 next_state;
   port_pkg::cs_count_t    cs_code;
   logic                   cs_valid;
   logic [7:0]             cs_value;
   logic [7:0]             cs_enable;
   logic [7:0]             cs_od_eff;
   logic [7:0]             third_value;
   logic [4:0]             cs_alt_sel;

   // Chip-select lines taken by the latched count, lowest lines first.
   function automatic logic [4:0] cs_mask(input port_pkg::cs_count_t code);
      unique case (code)
         port_pkg::CS_NONE:  cs_mask = 5'b00000;
         port_pkg::CS_TWO:   cs_mask = 5'b00011;
         port_pkg::CS_THREE: cs_mask = 5'b00111;
         port_pkg::CS_FIVE:  cs_mask = 5'b11111;
      endcase
   endfunction

   // Output lines read back their latch, input lines the pin.
   function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir,
                                            input logic [7:0] pin);
      port_read = (latch & dir) | (pin & ~dir);
   endfunction

   strap_capture u_strap (
      .clk   (clk),
      .rst   (rst),
      .strap (cs_count_strap),
      .code  (cs_code),
      .valid (cs_valid)
   );

   // Until the strap is caught no line counts as a chip select.
   assign cs_alt_sel = cs_valid ? cs_mask(cs_code) : 5'b00000;

   always_comb begin
      cs_value  = state.cs_data;
      cs_enable = state.cs_dir;
      cs_od_eff = state.cs_od;
      for (int i = 0; i < 5; i++) begin
         if (cs_alt_sel[i]) begin
            cs_value[i] = chip_select_n[i];
            // In hold mode another master owns the wired chip selects.
            cs_enable[i] = ~hold_mode;
         end
      end
      if (arbitration_enable) begin
         cs_enable[port_pkg::HOLD_REQ_LINE] = 1'b0;
         cs_value[port_pkg::HOLD_ACK_LINE]  = bus_hold_ack_n;
         cs_enable[port_pkg::HOLD_ACK_LINE] = 1'b1;
         cs_value[port_pkg::BUS_REQ_LINE]   = bus_request_n;
         cs_enable[port_pkg::BUS_REQ_LINE]  = 1'b1;
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         // The latch inverts rather than gates, so a separate enable is needed to connect the channel.
         third_value[i] = state.third_data[i] ^ (pwm_output_enable[i] & pwm_channel_out[i]);
         third_value[i + 4] = state.third_data[i + 4] & capcmp_out[i];
      end
   end

   port_driver u_cs_drv (
      .clk        (clk),
      .rst        (rst),
      .value      (cs_value),
      .enable     (cs_enable),
      .open_drain (cs_od_eff),
      .pins       (cs_pins)
   );

   port_driver u_third_drv (
      .clk        (clk),
      .rst        (rst),
      .value      (third_value),
      .enable     (state.third_dir),
      .open_drain (state.third_od),
      .pins       (third_pins)
   );

   always_comb begin
      next_state = state;
      next_state.rdata = port_pkg::RESET_WORD;
      next_state.timer_alt = input_pins[15:port_pkg::TIMER_ALT_LSB];
      next_state.hold_req_n = arbitration_enable ? cs_pin_in[port_pkg::HOLD_REQ_LINE] : 1'b1;
      next_state.capcmp = third_pin_in[7:4];
      next_state.pull_on = 8'h00;
      for (int i = 0; i < 5; i++) begin
         next_state.pull_on[i] = cs_alt_sel[i] & hold_mode & ~state.cs_od[i];
      end
      if (bus.wr) begin
         unique case (bus.addr)
            port_pkg::ADDR_CS_PORT_DATA:          next_state.cs_data = bus.wdata[7:0];
            port_pkg::ADDR_CS_PORT_DIRECTION:     next_state.cs_dir = bus.wdata[7:0];
            port_pkg::ADDR_CS_PORT_OPEN_DRAIN:    next_state.cs_od = bus.wdata[7:0];
            port_pkg::ADDR_THIRD_PORT_DATA:       next_state.third_data = bus.wdata[7:0];
            port_pkg::ADDR_THIRD_PORT_DIRECTION:  next_state.third_dir = bus.wdata[7:0];
            port_pkg::ADDR_THIRD_PORT_OPEN_DRAIN: next_state.third_od = bus.wdata[7:0];
            default: ;
         endcase
      end
      if (bus.rd) begin
         unique case (bus.addr)
            port_pkg::ADDR_INPUT_PORT_DATA:       next_state.rdata = input_pins;
            port_pkg::ADDR_CS_PORT_DATA:
               next_state.rdata = {8'h00, port_read(state.cs_data, cs_enable, cs_pin_in)};
            port_pkg::ADDR_CS_PORT_DIRECTION:     next_state.rdata = {8'h00, state.cs_dir};
            port_pkg::ADDR_CS_PORT_OPEN_DRAIN:    next_state.rdata = {8'h00, state.cs_od};
            port_pkg::ADDR_THIRD_PORT_DATA:
               next_state.rdata = {8'h00, port_read(state.third_data, state.third_dir, third_pin_in)};
            port_pkg::ADDR_THIRD_PORT_DIRECTION:  next_state.rdata = {8'h00, state.third_dir};
            port_pkg::ADDR_THIRD_PORT_OPEN_DRAIN: next_state.rdata = {8'h00, state.third_od};
            port_pkg::ADDR_RESET_CONFIG_READBACK:
               next_state.rdata = 16'(cs_code) << port_pkg::CS_CODE_LSB;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= '{cs_data: port_pkg::RESET_PORT_BYTE, cs_dir: port_pkg::RESET_PORT_BYTE,
                    cs_od: port_pkg::RESET_PORT_BYTE, third_data: port_pkg::RESET_PORT_BYTE,
                    third_dir: port_pkg::RESET_PORT_BYTE, third_od: port_pkg::RESET_PORT_BYTE,
                    rdata: port_pkg::RESET_WORD, timer_alt: 6'h00, hold_req_n: 1'b1,
                    capcmp: 4'h0, pull_on: 8'h1f};
      end else begin
         state <= next_state;
      end
   end

   assign rdata          = state.rdata;
   assign timer_alt_in   = state.timer_alt;
   assign hold_request_n = state.hold_req_n;
   assign capcmp_in      = state.capcmp;
   assign cs_pullup      = state.pull_on;

endmodule // port5_6_7_io_ports

//--- core/port_pkg.sv
// Package with register map, reset values and pin carrier types of the port block.
package port_pkg;

   localparam logic [15:0] ADDR_INPUT_PORT_DATA        = 16'hffa2;
   localparam logic [15:0] ADDR_CS_PORT_DATA           = 16'hffcc;
   localparam logic [15:0] ADDR_CS_PORT_DIRECTION      = 16'hffce;
   localparam logic [15:0] ADDR_CS_PORT_OPEN_DRAIN     = 16'hf1ce;
   localparam logic [15:0] ADDR_THIRD_PORT_DATA        = 16'hffd0;
   localparam logic [15:0] ADDR_THIRD_PORT_DIRECTION   = 16'hffd2;
   localparam logic [15:0] ADDR_THIRD_PORT_OPEN_DRAIN  = 16'hf1d2;
   localparam logic [15:0] ADDR_RESET_CONFIG_READBACK  = 16'hf1e0;

   localparam logic [7:0]  RESET_PORT_BYTE             = 8'h00;
   localparam logic [15:0] RESET_WORD                  = 16'h0000;
   localparam int          CS_CODE_LSB                 = 1;
   localparam int          TIMER_ALT_LSB               = 10;
   localparam int          HOLD_REQ_LINE               = 5;
   localparam int          HOLD_ACK_LINE               = 6;
   localparam int          BUS_REQ_LINE                = 7;

   // Strap code caught after reset, giving the number of chip-select lines.
   typedef enum logic [1:0] {
      CS_NONE  = 2'b00,
      CS_TWO   = 2'b01,
      CS_THREE = 2'b10,
      CS_FIVE  = 2'b11
   } cs_count_t;

   // One byte-wide group of two-way pins as the pads see it.
   typedef struct packed {
      logic [7:0] value;
      logic [7:0] drive_n;
   } pin_drive_t;

   // Register bus request.
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

endpackage

//--- core/strap_capture.sv
// Catches the chip-select count strap on the first clock edge after reset release.
module strap_capture (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [1:0]          strap,
   output port_pkg::cs_count_t      code,
   output logic                     valid
);

   typedef struct packed {
      port_pkg::cs_count_t code;
      logic                valid;
   } state_t;

   state_t state;
   state_t next_state;

   always_comb begin
      next_state = state;
      if (!state.valid) begin
         next_state.code  = port_pkg::cs_count_t'(strap);
         next_state.valid = 1'b1;
      end
   end

   // The strap is a pin level, so it is sampled by the clock, never loaded by the reset itself.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= '{code: port_pkg::CS_NONE, valid: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign code  = state.code;
   assign valid = state.valid;

endmodule // strap_capture

//--- core/port_driver.sv
// Registered push/pull or open-drain driver for one byte of two-way pins.
module port_driver (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [7:0]          value,
   input  wire logic [7:0]          enable,
   input  wire logic [7:0]          open_drain,
   output port_pkg::pin_drive_t     pins
);

   port_pkg::pin_drive_t state;
   port_pkg::pin_drive_t next_state;

   always_comb begin
      next_state.value = value;
      // Open drain only pulls low; a high level is left to the pullup.
      next_state.drive_n = ~(enable & (~open_drain | ~value));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= '{value: 8'h00, drive_n: 8'hff};
      end else begin
         state <= next_state;
      end
   end

   assign pins = state;

endmodule // port_driver

//--- verification/port_board.sv
// Board model of one byte of two-way lines with a second driver and a floating fallback.
module port_board (
   input  wire logic                 clk,
   input  wire port_pkg::pin_drive_t pins,
   input  wire logic [7:0]           pull_on,
   input  wire logic [7:0]           ext_n,
   input  wire logic [7:0]           ext_v,
   output logic [7:0]                level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last = 8'h00;
   logic [7:0] drv;
   // Driven lines resolve as wired-AND; a released line without pullup flips each cycle, so stale data never passes.
   assign drv = ~pins.drive_n | ~ext_n;
   assign level = (drv & (pins.value | pins.drive_n) & (ext_v | ext_n)) | (~drv & (pull_on | ~last));
   always @(posedge clk) last <= level;
endmodule // port_board

//--- verification/port5_6_7_io_ports_properties.sv
// Concurrent checks on the port block's pins and register bus.
module port5_6_7_io_ports_properties (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire port_pkg::bus_req_t   bus,
   input  wire logic [15:0]          rdata,
   input  wire logic [15:0]          input_pins,
   input  wire logic [5:0]           timer_alt_in,
   input  wire logic [1:0]           cs_count_strap,
   input  wire logic                 arbitration_enable,
   input  wire logic                 hold_mode,
   input  wire logic                 hold_request_n,
   input  wire port_pkg::pin_drive_t cs_pins,
   input  wire logic [7:0]           cs_pullup,
   input  wire logic [3:0]           capcmp_in,
   input  wire logic [7:0]           third_pin_in,
   input  wire port_pkg::pin_drive_t third_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_at(logic [15:0] a);
      bus.rd && bus.addr == a;
   endsequence
   rd_idle_a: assert property (!bus.rd |=> rdata == 16'h0000) else $error("read data not idle");
   input_read_a: assert property (rd_at(port_pkg::ADDR_INPUT_PORT_DATA) |=> rdata == $past(input_pins))
      else $error("input port read wrong");
   readback_a: assert property (rd_at(port_pkg::ADDR_RESET_CONFIG_READBACK)
      |=> rdata == {13'h0000, cs_count_strap, 1'b0}) else $error("readback wrong");
   timer_copy_a: assert property (!$past(rst) |-> timer_alt_in == 6'($past(input_pins) >> 10))
      else $error("timer input copy wrong");
   capcmp_copy_a: assert property (!$past(rst) |-> capcmp_in == 4'($past(third_pin_in) >> 4))
      else $error("capture input copy wrong");
   reset_state_a: assert property (@(posedge clk) disable iff (1'b0) rst |-> cs_pullup == 8'h1f
      && cs_pins.drive_n == 8'hff && third_pins.drive_n == 8'hff) else $error("reset pad state wrong");
   // The release edge still loads the reset pullup value, so attempts start only once reset is low.
   pullup_idle_a: assert property (!rst && !hold_mode |=> cs_pullup == 8'h00)
      else $error("pullup on outside hold");
   hold_req_a: assert property (!arbitration_enable |=> hold_request_n) else $error("hold request not idle");
   // An open-drain arbitration output leaves a high level undriven, so only low levels must be driven.
   arb_dir_a: assert property (arbitration_enable [*2] |-> cs_pins.drive_n[5]
      && (~cs_pins.value[7:6] & cs_pins.drive_n[7:6]) == 2'b00) else $error("arbitration directions wrong");
endmodule // port5_6_7_io_ports_properties

bind port5_6_7_io_ports port5_6_7_io_ports_properties u_port5_6_7_io_ports_properties (.clk(clk), .rst(rst),
   .bus(bus), .rdata(rdata), .input_pins(input_pins), .timer_alt_in(timer_alt_in), .cs_count_strap(cs_count_strap),
   .arbitration_enable(arbitration_enable), .hold_mode(hold_mode), .hold_request_n(hold_request_n),
   .cs_pins(cs_pins), .cs_pullup(cs_pullup), .capcmp_in(capcmp_in), .third_pin_in(third_pin_in),
   .third_pins(third_pins));

//--- verification/port5_6_7_io_ports_test.sv
// Self-checking bench for the three port units with board models on both two-way ports.
module port5_6_7_io_ports_test;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
   localparam logic [15:0] ADR[6] = '{port_pkg::ADDR_CS_PORT_DATA, port_pkg::ADDR_CS_PORT_DIRECTION,
      port_pkg::ADDR_CS_PORT_OPEN_DRAIN, port_pkg::ADDR_THIRD_PORT_DATA, port_pkg::ADDR_THIRD_PORT_DIRECTION,
      port_pkg::ADDR_THIRD_PORT_OPEN_DRAIN};
   logic                 clk, rst, arb, hold, ack_n, bus_request_n_n, hreq_n;
   port_pkg::bus_req_t   bus;
   port_pkg::pin_drive_t cs_pins, th_pins;
   logic [15:0]          rdata, in_pins;
   logic [7:0]           cs_lvl, th_lvl, cs_pu, ext_n, ext_v, m, v, drv;
   logic [7:0]           cfg[3];
   logic [5:0]           talt;
   logic [4:0]           csel_n;
   logic [3:0]           pwm, pen, ccout, ccin;
   logic [1:0]           strap;
   integer               err_total = 0, check_count = 0, seed = 32'h71be5ebf, n;
   port5_6_7_io_ports u_port5_6_7_io_ports (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .input_pins(in_pins),
      .timer_alt_in(talt), .cs_count_strap(strap), .chip_select_n(csel_n), .arbitration_enable(arb),
      .hold_mode(hold), .bus_hold_ack_n(ack_n), .bus_request_n(bus_request_n_n), .hold_request_n(hreq_n),
      .cs_pin_in(cs_lvl), .cs_pins(cs_pins), .cs_pullup(cs_pu), .pwm_channel_out(pwm), .pwm_output_enable(pen),
      .capcmp_out(ccout), .capcmp_in(ccin), .third_pin_in(th_lvl), .third_pins(th_pins));
   port_board u_cs_board (.clk(clk), .pins(cs_pins), .pull_on(cs_pu), .ext_n(ext_n), .ext_v(ext_v), .level(cs_lvl));
   port_board u_th_board (.clk(clk), .pins(th_pins), .pull_on(8'h00), .ext_n(ext_n), .ext_v(ext_v), .level(th_lvl));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input string nm);
      @(posedge clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      #1 `CHK(nm, e, rdata)
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic [1:0] c);
      @(posedge clk) begin
         rst <= 1'b1;
         strap <= c;
         csel_n <= 5'($random(seed));
      end
      #1 `CHK("reset pullup", 8'h1f, cs_pu)
      `CHK("reset drive", 16'hffff, {cs_pins.drive_n, th_pins.drive_n})
      repeat (16) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic results;
      $display("Checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      // Raised late in time zero so the asynchronous reset sees a rising edge.
      rst <= 1'b1;
      bus = '0;
      in_pins = 16'h0000;
      strap = 2'b00;
      csel_n = 5'h1f;
      {arb, hold, ack_n, bus_request_n_n} = 4'b0011;
      {ext_n, ext_v} = 16'hff00;
      {pwm, pen, ccout} = 12'h000;
      // Walk every strap code; the last one leaves the whole byte as plain I/O.
      for (int c = 3; c >= 0; c--) begin
         n = c == 3 ? 5 : c == 0 ? 0 : c + 1;
         m = 8'((1 << n) - 1);
         do_reset(2'(c));
         rd(port_pkg::ADDR_RESET_CONFIG_READBACK, 16'(c) << 1, "readback");
         rd(port_pkg::ADDR_CS_PORT_DIRECTION, 16'h0000, "cs dir");
         rd(port_pkg::ADDR_THIRD_PORT_OPEN_DRAIN, 16'h0000, "third od");
         settle;
         `CHK("cs select drive", ~m, cs_pins.drive_n)
         `CHK("cs select value", csel_n & m[4:0], cs_pins.value[4:0] & m[4:0])
         @(posedge clk) hold <= 1'b1;
         settle;
         `CHK("hold pullup", m, cs_pu)
         wr(port_pkg::ADDR_CS_PORT_OPEN_DRAIN, 16'h00ff);
         settle;
         `CHK("od pullup", 8'h00, cs_pu)
         @(posedge clk) hold <= 1'b0;
      end
      @(posedge clk) in_pins <= 16'($random(seed));
      wr(port_pkg::ADDR_INPUT_PORT_DATA, 16'h5a5a);
      rd(port_pkg::ADDR_INPUT_PORT_DATA, in_pins, "input port");
      `CHK("timer alt", in_pins[15:10], talt)
      rd(16'h1234, 16'h0000, "unmapped");
      repeat (8) begin
         foreach (cfg[i]) cfg[i] = 8'($random(seed));
         @(posedge clk) begin
            {pwm, pen, ccout} <= 12'($random(seed));
            ext_v <= 8'($random(seed));
            ext_n <= cfg[1];
         end
         foreach (ADR[i]) wr(ADR[i], {8'h00, cfg[i % 3]});
         settle;
         v = {cfg[0][7:4] & ccout, cfg[0][3:0] ^ (pwm & pen)};
         drv = cfg[1] & ~(cfg[2] & v);
         `CHK("third drive", ~drv, th_pins.drive_n)
         `CHK("third value", v & drv, th_pins.value & drv)
         drv = cfg[1] & ~(cfg[2] & cfg[0]);
         `CHK("cs drive", ~drv, cs_pins.drive_n)
         `CHK("cs value", cfg[0] & drv, cs_pins.value & drv)
         `CHK("capture in", ext_v[7:4] & ~cfg[1][7:4], ccin & ~cfg[1][7:4])
         rd(port_pkg::ADDR_CS_PORT_OPEN_DRAIN, {8'h00, cfg[2]}, "cs od");
         rd(port_pkg::ADDR_CS_PORT_DATA, {8'h00, (cfg[1] & cfg[0]) | (~cfg[1] & ext_v)}, "cs data");
         rd(port_pkg::ADDR_THIRD_PORT_DATA, {8'h00, (cfg[1] & cfg[0]) | (~cfg[1] & ext_v)}, "third data");
      end
      wr(port_pkg::ADDR_CS_PORT_OPEN_DRAIN, 16'h0000);
      @(posedge clk) begin
         arb <= 1'b1;
         {ack_n, bus_request_n_n} <= 2'b01;
         {ext_n, ext_v} <= 16'hdf00;
      end
      settle;
      `CHK("hold request", 1'b0, hreq_n)
      `CHK("arb drive", 3'b001, cs_pins.drive_n[7:5])
      `CHK("arb value", 2'b10, cs_pins.value[7:6])
      results;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      results;
   end
endmodule // port5_6_7_io_ports_test
